/* File: rtl/frs_cfg.svh */
// register map, reset values and timing of the frequency reference selector
// Behaviour
// - main source: knob, pot, ai1, ai2, updown1, updown2, multi, pid, host, program
// - updown mode 1 keeps its reached setting when the drive stops
// - updown mode 2 reloads the digital setting when the drive stops
// - main frequency is selected source times main gain
// - multi-speed step zero source: pot, digital setting, ai1 or ai2
// - aux source: ai1, ai2, polarity ai1, polarity ai2, pid
// - polarity aux sources apply a dead zone around the centre point
// - aux range base: maximum output frequency or main frequency
// - aux frequency is the range base times aux gain, 0 to 100 percent
// - combine: main, aux, sum, difference, traverse
// - codes 4 to 6 switch main against aux, sum or difference by terminal
// - code 7 takes the larger, code 8 the smaller of main and aux
// - updown value starts at digital setting; store selects power-off retention
// - digital setting is 0 up to the high limit, used as preset
// - panel control: output direction same as or opposite to command
// - output never exceeds maximum output frequency, 50 to 400 Hz
// - settings confined between low and high limits, high at or below maximum
// - acceleration spans zero to maximum in accel time, 0.1 to 3600 s
// - deceleration spans maximum to zero in decel time, 0.1 to 3600 s
// - ramp group 1 default, terminals or program choose others
// - parameter init 1 clears fault history, 0 is normal
// - init 2 restores defaults, init 3 locks other parameters
`ifndef FRS_CFG_SVH
`define FRS_CFG_SVH
`define FRS_A_MSRC 8'h00
`define FRS_A_MZERO 8'h04
`define FRS_A_ASRC 8'h08
`define FRS_A_ARB 8'h0c
`define FRS_A_AGAIN 8'h10
`define FRS_A_COMB 8'h14
`define FRS_A_USTORE 8'h18
`define FRS_A_DIGF 8'h1c
`define FRS_A_RDIR 8'h20
`define FRS_A_FMAX 8'h24
`define FRS_A_FHIGH 8'h28
`define FRS_A_FLOW 8'h2c
`define FRS_A_ACC1 8'h30
`define FRS_A_DEC1 8'h34
`define FRS_A_PINIT 8'h38
`define FRS_A_DZ 8'h3c
`define FRS_A_MGAIN 8'h40
`define FRS_A_FOUT 8'h44
`define FRS_A_TGT 8'h48
`define FRS_A_UD 8'h4c
`define FRS_A_HIST 3'h3
`define FRS_A_RAMP 3'h4
`define FRS_D_DIGF 16'h1388
`define FRS_D_FMAX 16'h1388
`define FRS_D_FHIGH 16'h1388
`define FRS_D_TIME 16'h0064
`define FRS_D_GAIN 16'h0064
`define FRS_FMAX_MIN 16'h1388
`define FRS_FMAX_MAX 16'h9c40
`define FRS_TIME_MIN 16'h0001
`define FRS_TIME_MAX 16'h8ca0
`define FRS_AI_MID 12'h800
`define FRS_CLK_HZ 20000000
`define FRS_RAMP_UNIT_MS 100
`define FRS_RAMP_UNIT_CYC (`FRS_RAMP_UNIT_MS * (`FRS_CLK_HZ / 1000))
`define FRS_UD_STEP_MS 10
`define FRS_UD_STEP_CYC (`FRS_UD_STEP_MS * (`FRS_CLK_HZ / 1000))
`endif

/* File: rtl/frs_pkg.sv */
// types of the frequency reference selector
package frs_pkg;
    typedef enum logic [3:0] {MS_KNOB, MS_POT, MS_AI1, MS_AI2, MS_UD1, MS_UD2,
        MS_MULTI, MS_PID, MS_HOST, MS_PROG} frs_msrc_t;
    typedef enum logic [2:0] {AX_AI1, AX_AI2, AX_PAI1, AX_PAI2, AX_PID} frs_asrc_t;
    typedef enum logic [3:0] {CB_MAIN, CB_AUX, CB_SUM, CB_DIFF, CB_SW_AUX, CB_SW_SUM,
        CB_SW_DIFF, CB_MAX, CB_MIN, CB_TRAV} frs_comb_t;
    typedef enum logic [1:0] {PI_NONE, PI_CLEAR, PI_RESTORE, PI_LOCK} frs_pinit_t;
    typedef struct packed {
        frs_msrc_t msrc;
        logic [1:0] mzero;
        frs_asrc_t asrc;
        logic arb;
        logic [6:0] again;
        logic [7:0] mgain;
        frs_comb_t comb;
        logic ustore;
        logic [15:0] digf;
        logic rdir;
        logic [15:0] fmax;
        logic [15:0] fhigh;
        logic [15:0] flow;
        logic [3:0][15:0] acc;
        logic [3:0][15:0] dec;
        frs_pinit_t pinit;
        logic [15:0] dz;
        logic [7:0][15:0] hist;
        logic [6:0][2:0] sh;
        logic [6:0] pq;
        logic run_d;
        logic [15:0] ud;
        logic [31:0] udcnt;
        logic [15:0] tgt;
        logic [15:0] fout;
        logic [47:0] dda;
        logic dir;
        logic ack;
        logic [31:0] rdata;
    } frs_state_t;
endpackage

/* File: rtl/frs_top.sv */
// frequency reference selection, limits, ramp and parameter commands
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "frs_cfg.svh"
module frs_top import frs_pkg::*; #(
    parameter int unsigned RAMP_UNIT_CYC = `FRS_RAMP_UNIT_CYC,
    parameter int unsigned UD_STEP_CYC = `FRS_UD_STEP_CYC
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // control terminals, asynchronous
    input wire logic up_term_in,
    input wire logic down_term_in,
    input wire logic switch_term_in,
    input wire logic run_in,
    input wire logic cmd_dir_in,
    input wire logic panel_ctrl_in,
    input wire logic [1:0] ramp_group_term_in,
    // frequency sources, same clock
    input wire logic [15:0] knob_freq_in,
    input wire logic [11:0] pot_in,
    input wire logic [11:0] analog_input_1_in,
    input wire logic [11:0] analog_input_2_in,
    input wire logic [11:0] pid_in,
    input wire logic [15:0] host_freq_in,
    input wire logic [15:0] multi_freq_in,
    input wire logic multi_step_zero_in,
    input wire logic [15:0] program_freq_in,
    input wire logic [1:0] program_group_in,
    input wire logic [15:0] traverse_freq_in,
    // fault log and updown retention
    input wire logic fault_valid_in,
    input wire logic [15:0] fault_code_in,
    input wire logic ud_restore_valid_in,
    input wire logic [15:0] ud_restore_in,
    // outputs
    output logic [15:0] freq_out,
    output logic [15:0] set_freq_out,
    output logic dir_out,
    output logic [15:0] updown_value_out,
    output logic updown_retain_out
);
    localparam int P_UP = 0;
    localparam int P_DN = 1;
    localparam int P_SW = 2;
    localparam int P_RUN = 3;
    localparam int P_DIR = 4;
    localparam int P_PAN = 5;
    localparam int P_GRP = 6;

    frs_state_t s;
    frs_state_t n;

    function automatic logic [15:0] clamp(input logic [15:0] v, lo, hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // fraction of full scale times a reference; divide by 4095 so full scale gives the reference
    function automatic logic [15:0] scale(input logic [11:0] f, input logic [15:0] r);
        logic [27:0] p;
        p = 28'(f) * 28'(r);
        scale = 16'(p / 28'd4095);
    endfunction

    function automatic frs_state_t defaults(input frs_state_t x);
        frs_state_t y;
        y = x;
        y.msrc = MS_KNOB;
        y.mzero = 2'h0;
        y.asrc = AX_AI1;
        y.arb = 1'b0;
        y.again = 7'(`FRS_D_GAIN);
        y.mgain = 8'(`FRS_D_GAIN);
        y.comb = CB_MAIN;
        y.ustore = 1'b0;
        y.digf = `FRS_D_DIGF;
        y.rdir = 1'b0;
        y.fmax = `FRS_D_FMAX;
        y.fhigh = `FRS_D_FHIGH;
        y.flow = 16'h0;
        y.acc = {4{`FRS_D_TIME}};
        y.dec = {4{`FRS_D_TIME}};
        y.pinit = PI_NONE;
        y.dz = 16'h0;
        return y;
    endfunction

    function automatic frs_state_t power_on();
        frs_state_t y;
        y = defaults(frs_state_t'(0));
        y.ud = `FRS_D_DIGF;
        return y;
    endfunction

    function automatic logic [15:0] rd_reg(input frs_state_t x, input logic [7:0] a);
        rd_reg = 16'h0;
        if (a == `FRS_A_MSRC) begin
            rd_reg = 16'(x.msrc);
        end else if (a == `FRS_A_MZERO) begin
            rd_reg = 16'(x.mzero);
        end else if (a == `FRS_A_ASRC) begin
            rd_reg = 16'(x.asrc);
        end else if (a == `FRS_A_ARB) begin
            rd_reg = 16'(x.arb);
        end else if (a == `FRS_A_AGAIN) begin
            rd_reg = 16'(x.again);
        end else if (a == `FRS_A_COMB) begin
            rd_reg = 16'(x.comb);
        end else if (a == `FRS_A_USTORE) begin
            rd_reg = 16'(x.ustore);
        end else if (a == `FRS_A_DIGF) begin
            rd_reg = x.digf;
        end else if (a == `FRS_A_RDIR) begin
            rd_reg = 16'(x.rdir);
        end else if (a == `FRS_A_FMAX) begin
            rd_reg = x.fmax;
        end else if (a == `FRS_A_FHIGH) begin
            rd_reg = x.fhigh;
        end else if (a == `FRS_A_FLOW) begin
            rd_reg = x.flow;
        end else if (a == `FRS_A_ACC1) begin
            rd_reg = x.acc[0];
        end else if (a == `FRS_A_DEC1) begin
            rd_reg = x.dec[0];
        end else if (a == `FRS_A_PINIT) begin
            rd_reg = 16'(x.pinit);
        end else if (a == `FRS_A_DZ) begin
            rd_reg = x.dz;
        end else if (a == `FRS_A_MGAIN) begin
            rd_reg = 16'(x.mgain);
        end else if (a == `FRS_A_FOUT) begin
            rd_reg = x.fout;
        end else if (a == `FRS_A_TGT) begin
            rd_reg = x.tgt;
        end else if (a == `FRS_A_UD) begin
            rd_reg = x.ud;
        end else if (a[7:5] == `FRS_A_HIST && a[1:0] == 2'h0) begin
            rd_reg = x.hist[a[4:2]];
        end else if (a[7:5] == `FRS_A_RAMP && a[1:0] == 2'h0) begin
            rd_reg = a[2] ? x.dec[a[4:3]] : x.acc[a[4:3]];
        end
    endfunction

    logic req;
    logic wr_acc;
    logic [15:0] oldv;
    logic [15:0] wv;
    logic [15:0] msel;
    logic [15:0] zsel;
    logic [23:0] main_w;
    logic [15:0] main_f;
    logic [11:0] afrac;
    logic aneg;
    logic [11:0] pv;
    logic [15:0] pd;
    logic [15:0] aref;
    logic [22:0] aux_w;
    logic signed [25:0] sm;
    logic signed [25:0] sa;
    logic signed [25:0] sres;
    logic [15:0] tg;
    logic [1:0] grp;
    logic [15:0] rtg;
    logic [15:0] tm;
    logic [47:0] den;
    logic [47:0] dsum;
    logic ud_tick;
    logic stop_ev;

    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~s.ack;
    assign avs_readdata_out = s.rdata;
    assign freq_out = s.fout;
    assign set_freq_out = s.tgt;
    assign dir_out = s.dir;
    assign updown_value_out = s.ud;
    assign updown_retain_out = ~s.ustore;

    always_comb begin
        n = s;
        // one wait state: request seen, answered on the next edge
        n.ack = req & ~s.ack;
        oldv = rd_reg(s, avs_address_in);
        if (req & ~s.ack) begin
            n.rdata = {16'h0, oldv};
        end
        wv = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : oldv[15:8],
              avs_byteenable_in[0] ? avs_writedata_in[7:0] : oldv[7:0]};
        wr_acc = avs_write_in & s.ack &
                 ((s.pinit != PI_LOCK) || (avs_address_in == `FRS_A_PINIT));
        if (wr_acc && avs_address_in == `FRS_A_MSRC && wv <= 16'(MS_PROG)) begin
            n.msrc = frs_msrc_t'(wv[3:0]);
        end else if (wr_acc && avs_address_in == `FRS_A_MZERO) begin
            n.mzero = wv[1:0];
        end else if (wr_acc && avs_address_in == `FRS_A_ASRC && wv <= 16'(AX_PID)) begin
            n.asrc = frs_asrc_t'(wv[2:0]);
        end else if (wr_acc && avs_address_in == `FRS_A_ARB) begin
            n.arb = wv[0];
        end else if (wr_acc && avs_address_in == `FRS_A_AGAIN) begin
            n.again = 7'(clamp(wv, 16'h0, `FRS_D_GAIN));
        end else if (wr_acc && avs_address_in == `FRS_A_COMB && wv <= 16'(CB_TRAV)) begin
            n.comb = frs_comb_t'(wv[3:0]);
        end else if (wr_acc && avs_address_in == `FRS_A_USTORE) begin
            n.ustore = wv[0];
        end else if (wr_acc && avs_address_in == `FRS_A_DIGF) begin
            n.digf = clamp(wv, 16'h0, s.fhigh);
        end else if (wr_acc && avs_address_in == `FRS_A_RDIR) begin
            n.rdir = wv[0];
        end else if (wr_acc && avs_address_in == `FRS_A_FMAX) begin
            n.fmax = clamp(wv, `FRS_FMAX_MIN, `FRS_FMAX_MAX);
        end else if (wr_acc && avs_address_in == `FRS_A_FHIGH) begin
            n.fhigh = clamp(wv, s.flow, s.fmax);
        end else if (wr_acc && avs_address_in == `FRS_A_FLOW) begin
            n.flow = clamp(wv, 16'h0, s.fhigh);
        end else if (wr_acc && avs_address_in == `FRS_A_ACC1) begin
            n.acc[0] = clamp(wv, `FRS_TIME_MIN, `FRS_TIME_MAX);
        end else if (wr_acc && avs_address_in == `FRS_A_DEC1) begin
            n.dec[0] = clamp(wv, `FRS_TIME_MIN, `FRS_TIME_MAX);
        end else if (wr_acc && avs_address_in == `FRS_A_DZ) begin
            n.dz = wv;
        end else if (wr_acc && avs_address_in == `FRS_A_MGAIN) begin
            n.mgain = wv[7:0];
        end else if (wr_acc && avs_address_in[7:5] == `FRS_A_RAMP && ~avs_address_in[2]) begin
            n.acc[avs_address_in[4:3]] = clamp(wv, `FRS_TIME_MIN, `FRS_TIME_MAX);
        end else if (wr_acc && avs_address_in[7:5] == `FRS_A_RAMP) begin
            n.dec[avs_address_in[4:3]] = clamp(wv, `FRS_TIME_MIN, `FRS_TIME_MAX);
        end else if (wr_acc && avs_address_in == `FRS_A_PINIT) begin
            n.pinit = frs_pinit_t'(wv[1:0]);
            // restore defaults, then back to normal
            if (wv[1:0] == 2'(PI_RESTORE)) begin
                n = defaults(n);
            end
            if (wv[1:0] == 2'(PI_CLEAR)) begin
                n.hist = '0;
                n.pinit = PI_NONE;
            end
        end
        // keep limits ordered after any write
        n.fhigh = clamp(n.fhigh, 16'h0, n.fmax);
        n.flow = clamp(n.flow, 16'h0, n.fhigh);
        // digital setting never above the high limit
        n.digf = clamp(n.digf, 16'h0, n.fhigh);
        if (fault_valid_in) begin
            n.hist = {s.hist[6:0], fault_code_in};
        end
        // three-stage terminal sync, a change counts once stages two and three agree
        for (int i = 0; i < 7; i++) begin
            n.sh[i] = {s.sh[i][1:0], i == P_UP ? up_term_in : i == P_DN ? down_term_in :
                i == P_SW ? switch_term_in : i == P_RUN ? run_in : i == P_DIR ? cmd_dir_in :
                i == P_PAN ? panel_ctrl_in : ramp_group_term_in[0]};
            if (s.sh[i][1] == s.sh[i][2]) begin
                n.pq[i] = s.sh[i][2];
            end
        end
        n.run_d = s.pq[P_RUN];
        stop_ev = s.run_d & ~s.pq[P_RUN];
        // up/down terminal stepping on a slow enable
        ud_tick = (s.udcnt == UD_STEP_CYC - 1);
        n.udcnt = ud_tick ? 32'h0 : s.udcnt + 32'h1;
        if (ud_tick && (s.msrc == MS_UD1 || s.msrc == MS_UD2)) begin
            if (s.pq[P_UP] && !s.pq[P_DN] && s.ud < s.fhigh) begin
                n.ud = s.ud + 16'h1;
            end else if (s.pq[P_DN] && !s.pq[P_UP] && s.ud != 16'h0) begin
                n.ud = s.ud - 16'h1;
            end
        end
        // restore only when retention is on, reload on digital write otherwise
        if (ud_restore_valid_in && !s.ustore) begin
            n.ud = ud_restore_in;
        end else if (wr_acc && avs_address_in == `FRS_A_DIGF && s.ustore) begin
            n.ud = n.digf;
        end
        // mode 1 keeps its value at stop; only the restore or digital write above reloads it
        // mode 2 reloads at stop; mode 1 simply keeps its value
        if (stop_ev && s.msrc == MS_UD2) begin
            n.ud = s.digf;
        end
        n.ud = clamp(n.ud, 16'h0, n.fhigh);
        case (s.mzero)
            2'h0: zsel = scale(pot_in, s.fmax);
            2'h1: zsel = s.digf;
            2'h2: zsel = scale(analog_input_1_in, s.fmax);
            default: zsel = scale(analog_input_2_in, s.fmax);
        endcase
        case (s.msrc)
            MS_KNOB: msel = knob_freq_in;
            MS_POT: msel = scale(pot_in, s.fmax);
            MS_AI1: msel = scale(analog_input_1_in, s.fmax);
            MS_AI2: msel = scale(analog_input_2_in, s.fmax);
            MS_UD1, MS_UD2: msel = s.ud;
            MS_MULTI: msel = multi_step_zero_in ? zsel : multi_freq_in;
            MS_PID: msel = scale(pid_in, s.fmax);
            MS_HOST: msel = host_freq_in;
            MS_PROG: msel = program_freq_in;
            default: msel = 16'h0;
        endcase
        main_w = (24'(msel) * 24'(s.mgain)) / 24'd100;
        main_f = (main_w > 24'hffff) ? 16'hffff : main_w[15:0];
        // polarity with a dead zone about the centre
        pv = (s.asrc == AX_PAI2) ? analog_input_2_in : analog_input_1_in;
        aneg = pv < `FRS_AI_MID;
        pd = aneg ? 16'(`FRS_AI_MID - pv) : 16'(pv - `FRS_AI_MID);
        pd = (pd > s.dz) ? ((pd - s.dz) << 1) : 16'h0;
        case (s.asrc)
            AX_AI1: afrac = analog_input_1_in;
            AX_AI2: afrac = analog_input_2_in;
            AX_PAI1, AX_PAI2: afrac = (pd > 16'h0fff) ? 12'hfff : pd[11:0];
            AX_PID: afrac = pid_in;
            default: afrac = 12'h0;
        endcase
        if (s.asrc != AX_PAI1 && s.asrc != AX_PAI2) begin
            aneg = 1'b0;
        end
        aref = s.arb ? main_f : s.fmax;
        aux_w = (23'(scale(afrac, aref)) * 23'(s.again)) / 23'd100;
        sm = 26'(main_f);
        sa = aneg ? -26'(aux_w) : 26'(aux_w);
        case (s.comb)
            CB_MAIN: sres = sm;
            CB_AUX: sres = sa;
            CB_SUM: sres = sm + sa;
            CB_DIFF: sres = sm - sa;
            CB_SW_AUX: sres = s.pq[P_SW] ? sa : sm;
            CB_SW_SUM: sres = s.pq[P_SW] ? sm + sa : sm;
            CB_SW_DIFF: sres = s.pq[P_SW] ? sm - sa : sm;
            // larger or smaller of the two
            CB_MAX: sres = (sm > sa) ? sm : sa;
            CB_MIN: sres = (sm < sa) ? sm : sa;
            CB_TRAV: sres = 26'(traverse_freq_in);
            default: sres = sm;
        endcase
        // negative result clamps to zero first
        if (sres < 0) begin
            tg = 16'h0;
        end else begin
            tg = (sres > 26'(s.fhigh)) ? s.fhigh : sres[15:0];
        end
        n.tgt = clamp(tg, s.flow, s.fhigh);
        // group 1 unless terminals or the program pick another
        grp = (s.msrc == MS_PROG && s.pq[P_RUN]) ? program_group_in
              : {s.pq[P_GRP] & s.sh[P_GRP][2], s.pq[P_GRP]};
        // stopped drive ramps down to zero; start and stop shaping live elsewhere
        rtg = s.pq[P_RUN] ? s.tgt : 16'h0;
        tm = (s.fout < rtg) ? s.acc[grp] : s.dec[grp];
        den = 48'(tm) * 48'(RAMP_UNIT_CYC);
        dsum = s.dda + 48'(s.fmax);
        // up-ramp: fmax steps per accel time, one count at most per cycle
        // down-ramp: same rate from the decel time
        if (s.fout == rtg) begin
            n.dda = 48'h0;
        end else if (dsum >= den) begin
            n.dda = dsum - den;
            n.fout = (s.fout < rtg) ? s.fout + 16'h1 : s.fout - 16'h1;
        end else begin
            n.dda = dsum;
        end
        // never above the maximum output frequency
        if (n.fout > s.fmax) begin
            n.fout = s.fmax;
        end
        n.dir = s.pq[P_DIR] ^ (s.pq[P_PAN] & s.rdir);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= power_on();
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence req_wait_s;
        req && avs_waitrequest_out;
    endsequence
    sequence ans_s;
        req && !avs_waitrequest_out;
    endsequence
    bus_answer_a: assert property (req_wait_s ##0 $stable(req) [*1] |=> ans_s or !req)
        else $error("no answer one cycle after request");
    out_max_a: assert property (s.fout <= s.fmax)
        else $error("output above maximum frequency");
    set_limits_a: assert property (1 |=> s.tgt <= $past(s.fhigh) && s.tgt >= $past(s.flow))
        else $error("set frequency outside limits");
    ramp_step_a: assert property (s.fout > $past(s.fout) |-> s.fout == $past(s.fout) + 16'h1)
        else $error("up-ramp jumped more than one count");
    max_pick_a: assert property (s.comb == CB_MAX && sres >= 0 |-> sres >= sm && sres >= sa)
        else $error("max combine wrong");
    dir_follow_a: assert property (1 |=> dir_out == ($past(s.pq[P_DIR]) ^ ($past(s.pq[P_PAN]) & $past(s.rdir))))
        else $error("direction wrong");
    hist_clear_a: assert property (wr_acc && avs_address_in == `FRS_A_PINIT && wv[1:0] == 2'h1 && !fault_valid_in |=> s.hist == '0)
        else $error("fault history not cleared");
    lock_hold_a: assert property (s.pinit == PI_LOCK && avs_write_in && avs_address_in == `FRS_A_FMAX |=> $stable(s.fmax))
        else $error("locked parameter changed");
    ud_reload_a: assert property (stop_ev && s.msrc == MS_UD2 && !ud_restore_valid_in |=> s.ud == clamp($past(s.digf), 16'h0, s.fhigh))
        else $error("updown not reloaded at stop");
endmodule

/* File: verif/frs_far_model.sv */
// far-side sources and terminals of the frequency reference selector
`timescale 1ns/10ps
module frs_far_model (
    // clock and request
    input wire logic clk_in,
    input wire logic sw_req_in,
    // terminal and sources
    output logic sw_term_out,
    output logic [15:0] knob_out,
    output logic [15:0] host_out,
    output logic [11:0] ai_out
);
    // full scale keeps analog sources equal to their range base
    assign knob_out = 16'h0bb8;
    assign host_out = 16'h03e8;
    assign ai_out = 12'hfff;
    // terminal held as a level, changed after an edge
    always_ff @(posedge clk_in) begin
        sw_term_out <= sw_req_in;
    end
endmodule

/* File: verif/test_freq_reference_selector.sv */
// self-checking bench of the frequency reference selector
`timescale 1ns/10ps
module test_freq_reference_selector import frs_pkg::*; ;
    typedef struct packed {frs_msrc_t m; frs_comb_t c; logic b; logic [6:0] g; logic s;
        logic [15:0] e;} frs_row_t;
    logic clk_sys_in = 0, rst_n_in = 0, rd = 0, wr = 0, sw = 0, run = 0, fv = 0;
    logic up = 0, dn = 0, cdir = 1, pan = 1;
    logic [7:0] adr = 0;
    logic [15:0] wd = 0, fc = 0, knob, host, f0, fout, sfout;
    logic [11:0] ai;
    logic [31:0] q, rdata;
    logic wreq, swt, dir_o;
    int miscompares = 0, checked = 0, cyc = 0;
    frs_row_t rows [14] = '{'{MS_KNOB, CB_MAIN, 1'b0, 7'd20, 1'b0, 16'h0bb8},
        '{MS_HOST, CB_MAIN, 1'b0, 7'd20, 1'b0, 16'h03e8},
        '{MS_KNOB, CB_AUX, 1'b0, 7'd20, 1'b0, 16'h03e8},
        '{MS_KNOB, CB_SUM, 1'b0, 7'd20, 1'b0, 16'h0fa0},
        '{MS_KNOB, CB_DIFF, 1'b0, 7'd20, 1'b0, 16'h07d0},
        '{MS_KNOB, CB_MAX, 1'b0, 7'd20, 1'b0, 16'h0bb8},
        '{MS_KNOB, CB_MIN, 1'b0, 7'd20, 1'b0, 16'h03e8},
        '{MS_HOST, CB_DIFF, 1'b0, 7'd40, 1'b0, 16'h0000},
        '{MS_KNOB, CB_SUM, 1'b0, 7'd100, 1'b0, 16'h1388},
        '{MS_KNOB, CB_AUX, 1'b1, 7'd50, 1'b0, 16'h05dc},
        '{MS_KNOB, CB_SW_AUX, 1'b0, 7'd20, 1'b0, 16'h0bb8},
        '{MS_KNOB, CB_SW_AUX, 1'b0, 7'd20, 1'b1, 16'h03e8},
        '{MS_KNOB, CB_SW_SUM, 1'b0, 7'd20, 1'b1, 16'h0fa0},
        '{MS_KNOB, CB_SW_DIFF, 1'b0, 7'd20, 1'b1, 16'h07d0}};
    frs_far_model far (.clk_in(clk_sys_in), .sw_req_in(sw), .sw_term_out(swt), .knob_out(knob),
        .host_out(host), .ai_out(ai));
    frs_top #(.RAMP_UNIT_CYC(4), .UD_STEP_CYC(4)) uut (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_byteenable_in(4'h3), .avs_writedata_in({16'h0, wd}), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .up_term_in(up), .down_term_in(dn),
        .switch_term_in(swt), .run_in(run), .cmd_dir_in(cdir), .panel_ctrl_in(pan),
        .ramp_group_term_in({1'b0, sw}), .knob_freq_in(knob), .pot_in(ai),
        .analog_input_1_in(ai), .analog_input_2_in(ai), .pid_in(ai), .host_freq_in(host),
        .multi_freq_in(host), .multi_step_zero_in(sw), .program_freq_in(host),
        .program_group_in({1'b0, sw}), .traverse_freq_in(host), .fault_valid_in(fv),
        .fault_code_in(fc), .ud_restore_valid_in(1'b0), .ud_restore_in(16'h0),
        .freq_out(fout), .set_freq_out(sfout), .dir_out(dir_o), .updown_value_out(),
        .updown_retain_out());
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // request held until waitrequest is seen low, then released after that edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        if (n >= 100) begin
            miscompares++;
        end
        q = rdata;
        rd <= 0;
        wr <= 0;
    endtask
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rst_n_in <= 1;
        foreach (rows[i]) begin
            bus(1, 8'h00, 16'(rows[i].m));
            bus(1, 8'h14, 16'(rows[i].c));
            bus(1, 8'h0c, 16'(rows[i].b));
            bus(1, 8'h10, 16'(rows[i].g));
            sw <= rows[i].s;
            repeat (8) @(posedge clk_sys_in);
            bus(0, 8'h48, 16'h0);
            check(q, {16'h0, rows[i].e});
            check({16'h0, sfout}, {16'h0, rows[i].e});
            $display("row %0d done", i);
        end
        sw <= 0;
        bus(0, 8'h24, 16'h0);
        check(q, 32'h1388);
        bus(1, 8'h24, 16'hffff);
        bus(0, 8'h24, 16'h0);
        check(q, 32'h9c40);
        bus(1, 8'h24, 16'h1388);
        bus(0, 8'h1c, 16'h0);
        check(q, 32'h1388);
        bus(0, 8'h50, 16'h0);
        check(q, 32'h0);
        fc <= 16'h00a5;
        fv <= 1;
        @(posedge clk_sys_in);
        fv <= 0;
        bus(0, 8'h60, 16'h0);
        check(q, 32'h00a5);
        bus(1, 8'h38, 16'h1);
        bus(0, 8'h60, 16'h0);
        check(q, 32'h0);
        bus(1, 8'h38, 16'h3);
        bus(1, 8'h00, 16'h8);
        bus(0, 8'h00, 16'h0);
        check(q, 32'h0);
        bus(1, 8'h24, 16'h9c40);
        bus(0, 8'h24, 16'h0);
        check(q, 32'h1388);
        bus(1, 8'h38, 16'h0);
        $display("register tests done");
        // slow times give 8 cycles per count, below the one count per cycle cap
        bus(1, 8'h14, 16'(CB_MAIN));
        bus(1, 8'h30, 16'd10000);
        bus(1, 8'h34, 16'd10000);
        run <= 1;
        repeat (100) @(negedge clk_sys_in);
        f0 = fout;
        repeat (400) @(negedge clk_sys_in);
        check({31'h0, (fout - f0) inside {[16'd48:16'd52]}}, 32'h1);
        bus(1, 8'h20, 16'h1);
        repeat (8) @(posedge clk_sys_in);
        check({31'h0, dir_o}, 32'h0);
        bus(1, 8'h20, 16'h0);
        repeat (8) @(posedge clk_sys_in);
        check({31'h0, dir_o}, 32'h1);
        run <= 0;
        repeat (20) @(negedge clk_sys_in);
        f0 = fout;
        repeat (400) @(negedge clk_sys_in);
        check({31'h0, (f0 - fout) inside {[16'd48:16'd52]}}, 32'h1);
        $display("ramp tests done");
        give_verdict();
    end
endmodule
